// File: shared/ppwm_regs.svh
// Register offsets, reset values and timing counts of the port duty block.
`ifndef PPWM_REGS_SVH
`define PPWM_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PPWM_OFS_PORT_1_0 8'h10
`define PPWM_OFS_PORT_3_2 8'h11
`define PPWM_OFS_PORT_5_4 8'h12

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PPWM_HI_FIELD 7:4
`define PPWM_LO_FIELD 3:0

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define PPWM_DUTY_RESET 8'h00
`define PPWM_UNMAPPED_READ 8'h00
`define PPWM_DUTY_STATIC 4'hf
`define PPWM_MASTER_OFF 4'h0

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define PPWM_STEP_CYCLES 1
`define PPWM_STEPS 16

`endif

// File: shared/ppwm_pkg.sv
// Types shared by the port duty block.
package ppwm_pkg;
    typedef logic [3:0] ppwm_duty_type;
    typedef logic [7:0] ppwm_byte_type;
    typedef enum logic [1:0] {
        ppwm_sel_none,
        ppwm_sel_1_0,
        ppwm_sel_3_2,
        ppwm_sel_5_4
    } ppwm_sel_type;
    typedef enum {
        ppwm_osc_stopped,
        ppwm_osc_running
    } ppwm_osc_type;
endpackage

// File: shared/ppwm_reg_if.sv
// Interface between the control logic and the duty register store.
`timescale 1ns/1ps
interface ppwm_reg_if;
    logic wr;
    logic rd;
    ppwm_pkg::ppwm_sel_type sel;
    ppwm_pkg::ppwm_byte_type wdata;
    ppwm_pkg::ppwm_byte_type rdata;
    logic rvalid;
    ppwm_pkg::ppwm_duty_type duty [6];
    modport ctrl (output wr, output rd, output sel, output wdata,
                  input rdata, input rvalid, input duty);
    modport store (input wr, input rd, input sel, input wdata,
                   output rdata, output rvalid, output duty);
endinterface

// File: design/ppwm_duty_store.sv
// Duty register store with registered read data.
`timescale 1ns/1ps
`include "ppwm_regs.svh"
module ppwm_duty_store
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    ppwm_reg_if.store bus
);
    ppwm_pkg::ppwm_byte_type regs [3];
    logic [1:0] idx;
    logic hit;
    ppwm_pkg::ppwm_byte_type next_rdata;

    assign hit = (bus.sel != ppwm_pkg::ppwm_sel_none);
    assign idx = 2'(bus.sel) - 2'h1;
    assign next_rdata = hit ? regs[idx] : `PPWM_UNMAPPED_READ;

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_port_pair
            assign bus.duty[2 * g] = regs[g][`PPWM_LO_FIELD];
            assign bus.duty[2 * g + 1] = regs[g][`PPWM_HI_FIELD];
            always_ff @(posedge clk)
            begin
                if (!nrst)
                    regs[g] <= `PPWM_DUTY_RESET;
                else if (ce && bus.wr && hit && idx == 2'(g))
                    regs[g] <= bus.wdata;
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            bus.rdata <= `PPWM_UNMAPPED_READ;
            bus.rvalid <= 1'b0;
        end
        else if (ce)
        begin
            bus.rvalid <= bus.rd;
            if (bus.rd)
                bus.rdata <= next_rdata;
        end
    end
endmodule

// File: design/ppwm_port_pwm.sv
// Per-port PWM intensity block for ports 0 to 5.
`timescale 1ns/1ps
`include "ppwm_regs.svh"
module ppwm_port_pwm
#(
    parameter int STEP_CYCLES = `PPWM_STEP_CYCLES
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [3:0] master_intensity,
    output logic [5:0] port_pwm_on,
    output logic pwm_period_start
);
    generate
        if (STEP_CYCLES < 1)
        begin : g_bad_step
            $error("STEP_CYCLES must be at least 1.");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------------------
    function automatic ppwm_pkg::ppwm_sel_type decode_sel(input logic [7:0] a);
        case (a)
            `PPWM_OFS_PORT_1_0: decode_sel = ppwm_pkg::ppwm_sel_1_0;
            `PPWM_OFS_PORT_3_2: decode_sel = ppwm_pkg::ppwm_sel_3_2;
            `PPWM_OFS_PORT_5_4: decode_sel = ppwm_pkg::ppwm_sel_5_4;
            default: decode_sel = ppwm_pkg::ppwm_sel_none;
        endcase
    endfunction

    ppwm_reg_if rif ();

    assign rif.wr = reg_wr && !reg_rd;
    assign rif.rd = reg_rd;
    assign rif.sel = decode_sel(reg_addr);
    assign rif.wdata = reg_wdata;
    assign reg_rdata = rif.rdata;
    assign reg_rvalid = rif.rvalid;

    ppwm_duty_store u_store
    (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .bus(rif.store)
    );

    // ------------------------------------------------------------------------
    // Oscillator and PWM timebase
    // ------------------------------------------------------------------------
    localparam int PRE_W = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
    ppwm_pkg::ppwm_osc_type osc;
    ppwm_pkg::ppwm_osc_type next_osc;
    logic [PRE_W-1:0] pre;
    logic [3:0] step;
    logic step_tick;
    logic master_off;

    assign master_off = (master_intensity == `PPWM_MASTER_OFF);
    assign step_tick = (pre == PRE_W'(STEP_CYCLES - 1));

    always_comb
    begin
        case (osc)
            ppwm_pkg::ppwm_osc_stopped:
                next_osc = master_off ? ppwm_pkg::ppwm_osc_stopped
                                      : ppwm_pkg::ppwm_osc_running;
            ppwm_pkg::ppwm_osc_running:
                next_osc = master_off ? ppwm_pkg::ppwm_osc_stopped
                                      : ppwm_pkg::ppwm_osc_running;
            default:
                next_osc = ppwm_pkg::ppwm_osc_stopped;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            osc <= ppwm_pkg::ppwm_osc_stopped;
            pre <= '0;
            step <= 4'h0;
        end
        else if (ce)
        begin
            osc <= next_osc;
            if (next_osc == ppwm_pkg::ppwm_osc_stopped)
            begin
                pre <= '0;
                step <= 4'h0;
            end
            else if (osc == ppwm_pkg::ppwm_osc_running)
            begin
                pre <= step_tick ? '0 : pre + PRE_W'(1);
                if (step_tick)
                    step <= step + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Per-port duty compare
    // ------------------------------------------------------------------------
    logic [5:0] next_on;
    logic running;

    assign running = (osc == ppwm_pkg::ppwm_osc_running) && !master_off;

    genvar p;
    generate
        for (p = 0; p < 6; p++)
        begin : g_port
            logic is_static;
            assign is_static = (rif.duty[p] == `PPWM_DUTY_STATIC);
            assign next_on[p] = !running ? 1'b1
                              : is_static ? 1'b1
                              : (step <= rif.duty[p]);
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            port_pwm_on <= 6'h3f;
            pwm_period_start <= 1'b0;
        end
        else if (ce)
        begin
            port_pwm_on <= next_on;
            pwm_period_start <= running && step == 4'h0 && pre == '0;
        end
    end
endmodule

// File: dv/ppwm_asserts.sv
// Assertion checker for the port duty block.
`timescale 1ns/1ps
module ppwm_asserts
#(
    parameter int STEP_CYCLES = 1
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [3:0] master_intensity,
    input wire logic [5:0] port_pwm_on,
    input wire logic pwm_period_start
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_wr;
        ce && reg_wr && !reg_rd && reg_addr inside {8'h10, 8'h11, 8'h12};
    endsequence
    sequence s_rd;
        ce && reg_rd && $stable(reg_addr);
    endsequence
    sequence s_off;
        (ce && master_intensity == 4'h0) [*3];
    endsequence
    a_read_valid: assert property (ce && reg_rd |=> reg_rvalid) else $error("no rvalid");
    a_rvalid_cause: assert property (reg_rvalid && $past(ce) |-> $past(reg_rd))
        else $error("rvalid");
    a_wr_rd_back: assert property (s_wr ##1 s_rd |=> reg_rdata == $past(reg_wdata, 2))
        else $error("readback");
    a_unmapped_zero: assert property (ce && reg_rd
        && !(reg_addr inside {8'h10, 8'h11, 8'h12}) |=> reg_rdata == 8'h00)
        else $error("unmapped");
    a_off_static: assert property (s_off |=> port_pwm_on == 6'h3f) else $error("off");
    a_off_no_period: assert property (s_off |=> !pwm_period_start) else $error("osc");
    a_period_on: assert property (pwm_period_start |-> port_pwm_on == 6'h3f) else $error("on");
    a_pulse_single: assert property (pwm_period_start && ce |=> !pwm_period_start)
        else $error("pulse");
    a_freeze_hold: assert property (!ce |=> $stable(port_pwm_on) && $stable(reg_rvalid)
        && $stable(reg_rdata) && $stable(pwm_period_start)) else $error("freeze");
endmodule
bind ppwm_port_pwm ppwm_asserts #(.STEP_CYCLES(STEP_CYCLES)) i_ppwm_asserts (.clk(clk),
    .nrst(nrst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .master_intensity(master_intensity), .port_pwm_on(port_pwm_on),
    .pwm_period_start(pwm_period_start));

// File: dv/ppwm_host.sv
// Host model that issues register strobes.
`timescale 1ns/1ps
module ppwm_host
(
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
    end
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic rw);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = !rw;
        reg_rd = rw;
        @(negedge clk);
    endtask
    task automatic idle();
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
endmodule

// File: dv/tb.sv
// Self-checking testbench for the port duty block.
`timescale 1ns/1ps
module tb;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic [3:0] master_intensity = 4'h0;
    logic ce = 1'h1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, reg_rvalid, pwm_period_start;
    logic [5:0] port_pwm_on;
    logic [7:0] exp_q [$];
    logic [7:0] cnt [6];
    int err_total = 0;
    int cmp_count = 0;
    always #25 clk = ~clk;
    ppwm_host i_ppwm_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));
    ppwm_port_pwm #(.STEP_CYCLES(1)) i_ppwm_port_pwm (.clk(clk), .nrst(nrst), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .master_intensity(master_intensity),
        .port_pwm_on(port_pwm_on), .pwm_period_start(pwm_period_start));
    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_on(input logic [7:0] got, input logic [7:0] exp);
        chk_rd(got, exp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_ppwm_host.xfer(a, 8'h00, 1'h1);
    endtask
    task automatic close_out();
        $display("compares %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(negedge clk)
        if (reg_rvalid === 1'h1)
        begin
            if (exp_q.size() == 0)
                chk_rd(8'h01, 8'(exp_q.size()));
            else
                chk_rd(reg_rdata, exp_q.pop_front());
        end
    initial
    begin
        #250000;
        err_total++;
        close_out();
    end
    initial
    begin
        void'($urandom(32'h0d65371b));
        repeat (20) @(negedge clk);
        nrst = 1'h1;
        for (int a = 16; a < 20; a++)
            rd(8'(a), 8'h00);
        i_ppwm_host.idle();
        @(negedge clk);
        ce = 1'h0;
        i_ppwm_host.xfer(8'h10, 8'h5a, 1'h0);
        i_ppwm_host.xfer(8'h10, 8'h00, 1'h1);
        ce = 1'h1;
        rd(8'h10, 8'h00);
        for (int a = 0; a < 4; a++)
        begin
            d = 8'($urandom());
            i_ppwm_host.xfer(8'h10 + 8'(a), d, 1'h0);
            rd(8'h10 + 8'(a), (a < 3) ? d : 8'h00);
        end
        for (int n = 0; n < 16; n++)
        begin
            for (int r = 0; r < 3; r++)
                i_ppwm_host.xfer(8'h10 + 8'(r), {4'(n + 2 * r + 1), 4'(n + 2 * r)}, 1'h0);
            i_ppwm_host.idle();
            master_intensity = 4'($urandom_range(15, 1));
            @(negedge clk);
            for (int k = 0; k < 40 && pwm_period_start !== 1'h1; k++)
                @(negedge clk);
            chk_on({7'h0, pwm_period_start}, 8'h01);
            for (int p = 0; p < 6; p++)
                cnt[p] = 8'h00;
            repeat (16)
            begin
                for (int p = 0; p < 6; p++)
                    cnt[p] += 8'(port_pwm_on[p]);
                @(negedge clk);
            end
            chk_on({7'h0, pwm_period_start}, 8'h01);
            for (int p = 0; p < 6; p++)
                chk_on(cnt[p], 8'((n + p) % 16 + 1));
        end
        master_intensity = 4'h0;
        repeat (3) @(negedge clk);
        repeat (8)
        begin
            chk_on({2'h0, port_pwm_on}, 8'h3f);
            @(negedge clk);
        end
        chk_rd(8'(exp_q.size()), 8'h00);
        close_out();
    end
endmodule
